// *** src/tss_pkg.sv ***
// Shared constants for the turbine speed supervisor.
// Assumes a single 25 MHz clock; speeds in whole rpm, times in seconds.
package tss_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned RPM_W  = 12;
  localparam int unsigned SEC_W  = 7;
  localparam int unsigned FUNC_W = 3;

  // ----------------------------------------------------------------------
  // Setting defaults and ranges
  // ----------------------------------------------------------------------
  localparam logic [RPM_W-1:0]  RPM_MAX          = 12'he10;
  localparam logic [RPM_W-1:0]  RPM_MIN          = 12'h000;
  localparam logic [RPM_W-1:0]  OVER_THR_DEF     = 12'h708;
  localparam logic [RPM_W-1:0]  UNDER_THR_DEF    = 12'h000;
  localparam logic [RPM_W-1:0]  BAND_DEF         = 12'h000;
  localparam logic [SEC_W-1:0]  LOW_TIME_DEF     = 7'h0a;
  localparam logic [SEC_W-1:0]  LOW_TIME_MIN     = 7'h05;
  localparam logic [SEC_W-1:0]  LOW_TIME_MAX     = 7'h64;
  localparam logic [SEC_W-1:0]  GRACE_DEF        = 7'h00;
  localparam logic [SEC_W-1:0]  GRACE_MIN        = 7'h00;
  localparam logic [SEC_W-1:0]  GRACE_MAX        = 7'h0a;
  localparam logic [SEC_W-1:0]  RAMP_TIME_DEF    = 7'h0a;
  localparam logic [SEC_W-1:0]  RAMP_TIME_MIN    = 7'h01;
  localparam logic [SEC_W-1:0]  RAMP_TIME_MAX    = 7'h64;
  localparam logic [FUNC_W-1:0] RELAY_FUNC_DEF   = 3'h4;
  localparam logic [FUNC_W-1:0] RELAY_FUNC_CTRL  = 3'h2;
  localparam logic [FUNC_W-1:0] RELAY_FUNC_LOWSD = 3'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned CYC_PER_SEC   = SECOND_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_LOWSPD,
    ST_RAMP,
    ST_STOP
  } tss_state_e;

endpackage

// *** src/tss_sec_timer.sv ***
// Seconds timer: counts whole seconds while run is high.
// Assumes run drops for at least one cycle between two timed intervals.
`timescale 1ns/10ps
module tss_sec_timer #(
  parameter int unsigned CYC_PER_SEC = tss_pkg::CYC_PER_SEC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  tss_timer_if.tmr t
);

  localparam int unsigned DIV_W = $clog2(CYC_PER_SEC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_SEC - 1);

  logic [DIV_W-1:0]          div_q;
  logic [DIV_W-1:0]          div_d;
  logic [tss_pkg::SEC_W-1:0] sec_q;
  logic [tss_pkg::SEC_W-1:0] sec_d;
  logic                      exp_q;
  logic                      exp_d;

  // ----------------------------------------------------------------------
  // Divider and seconds count
  // ----------------------------------------------------------------------
  always_comb begin
    div_d = '0;
    sec_d = '0;
    if (t.run) begin
      div_d = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
      sec_d = sec_q;
      // Saturate so a stalled interval never wraps back to zero
      if (div_q == DIV_LAST && sec_q != '1) begin
        sec_d = sec_q + 1'b1;
      end
    end
    exp_d = t.run && (sec_d >= t.limit);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
      sec_q <= '0;
      exp_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sec_q <= sec_d;
      exp_q <= exp_d;
    end
  end

  assign t.expired = exp_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  exp_count_a: assert property (exp_q |-> sec_q >= $past(t.limit)) // R06
    else $error("Timer expired before its limit");
  idle_clear_a: assert property (!t.run |=> sec_q == '0 && !exp_q) // R10
    else $error("Timer not cleared while idle");

endmodule

// *** src/tss_supervisor.sv ***
// Turbine speed supervisor: overspeed, underspeed, skip bands and relay.
// Assumes speed, power and settings are synchronous to clk_i.
//
// Overview of operation
// R01 - Overspeed above threshold starts stop ramp
// R02 - Ramp length comes from stop ramp setting
// R03 - Function 2: relay closed only while controlling or low-speed motoring
// R04 - Low-speed motoring time limited, 5 to 100 s
// R05 - Never run inside three prohibited speed bands
// R06 - Overspeed tolerated for grace time first
// R07 - Underspeed threshold setting, default zero rpm
// R08 - Low speed without power ends in ramp
// R09 - Switch 4 enables supervision, disables pressure control
// R10 - Reset loads defaults; compare on speed update
`timescale 1ns/10ps
module tss_supervisor #(
  parameter int unsigned CYC_PER_SEC = tss_pkg::CYC_PER_SEC
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wind_switch_i,
  input  wire logic                        run_request_i,
  input  wire logic [tss_pkg::RPM_W-1:0]   speed_i,
  input  wire logic                        speed_valid_i,
  input  wire logic                        power_produced_i,
  input  wire logic [tss_pkg::RPM_W-1:0]   speed_request_i,
  input  wire logic                        cfg_load_i,
  input  wire logic [tss_pkg::RPM_W-1:0]   overspeed_threshold_i,
  input  wire logic [tss_pkg::RPM_W-1:0]   underspeed_threshold_i,
  input  wire logic [tss_pkg::SEC_W-1:0]   overspeed_grace_time_i,
  input  wire logic [tss_pkg::SEC_W-1:0]   low_speed_motoring_time_i,
  input  wire logic [tss_pkg::SEC_W-1:0]   stop_ramp_time_i,
  input  wire logic [3*tss_pkg::RPM_W-1:0] skip_band_lower_i,
  input  wire logic [3*tss_pkg::RPM_W-1:0] skip_band_upper_i,
  input  wire logic [tss_pkg::FUNC_W-1:0]  status_relay_function_i,
  output logic                             relay_closed_o,
  output logic                             ramp_start_o,
  output logic                             ramp_active_o,
  output logic [tss_pkg::SEC_W-1:0]        ramp_time_o,
  output logic                             min_speed_motoring_o,
  output logic                             in_control_o,
  output logic                             pressure_ctrl_enable_o,
  output logic [tss_pkg::RPM_W-1:0]        speed_target_o
);

  localparam int unsigned RW = tss_pkg::RPM_W;
  localparam int unsigned SW = tss_pkg::SEC_W;

  // ----------------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------------
  logic [RW-1:0]   over_thr_q, over_thr_d, under_thr_q, under_thr_d;
  logic [SW-1:0]   grace_q, grace_d, low_time_q, low_time_d;
  logic [SW-1:0]   ramp_time_q, ramp_time_d;
  logic [3*RW-1:0] band_lo_q, band_lo_d, band_hi_q, band_hi_d;
  logic [tss_pkg::FUNC_W-1:0] func_q, func_d;
  logic            wind_q, wind_d;

  function automatic logic [RW-1:0] clamp_rpm(input logic [RW-1:0] v);
    clamp_rpm = (v > tss_pkg::RPM_MAX) ? tss_pkg::RPM_MAX : v;
  endfunction

  function automatic logic [SW-1:0] clamp_sec(input logic [SW-1:0] v,
                                              input logic [SW-1:0] lo,
                                              input logic [SW-1:0] hi);
    clamp_sec = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    over_thr_d  = over_thr_q;
    under_thr_d = under_thr_q;
    grace_d     = grace_q;
    low_time_d  = low_time_q;
    ramp_time_d = ramp_time_q;
    band_lo_d   = band_lo_q;
    band_hi_d   = band_hi_q;
    func_d      = func_q;
    wind_d      = wind_switch_i;
    // Out-of-range writes are clamped rather than refused
    if (cfg_load_i) begin
      over_thr_d  = clamp_rpm(overspeed_threshold_i); // R01
      under_thr_d = clamp_rpm(underspeed_threshold_i); // R07
      grace_d     = clamp_sec(overspeed_grace_time_i, tss_pkg::GRACE_MIN,
                              tss_pkg::GRACE_MAX); // R06
      low_time_d  = clamp_sec(low_speed_motoring_time_i,
                              tss_pkg::LOW_TIME_MIN,
                              tss_pkg::LOW_TIME_MAX); // R04
      ramp_time_d = clamp_sec(stop_ramp_time_i, tss_pkg::RAMP_TIME_MIN,
                              tss_pkg::RAMP_TIME_MAX); // R02
      for (int i = 0; i < 3; i++) begin
        band_lo_d[i*RW +: RW] = clamp_rpm(skip_band_lower_i[i*RW +: RW]);
        band_hi_d[i*RW +: RW] = clamp_rpm(skip_band_upper_i[i*RW +: RW]);
      end
      func_d = status_relay_function_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin // R10
      over_thr_q  <= tss_pkg::OVER_THR_DEF;
      under_thr_q <= tss_pkg::UNDER_THR_DEF;
      grace_q     <= tss_pkg::GRACE_DEF;
      low_time_q  <= tss_pkg::LOW_TIME_DEF;
      ramp_time_q <= tss_pkg::RAMP_TIME_DEF;
      band_lo_q   <= {3{tss_pkg::BAND_DEF}};
      band_hi_q   <= {3{tss_pkg::BAND_DEF}};
      func_q      <= tss_pkg::RELAY_FUNC_DEF;
      wind_q      <= 1'b0;
    end else begin
      over_thr_q  <= over_thr_d;
      under_thr_q <= under_thr_d;
      grace_q     <= grace_d;
      low_time_q  <= low_time_d;
      ramp_time_q <= ramp_time_d;
      band_lo_q   <= band_lo_d;
      band_hi_q   <= band_hi_d;
      func_q      <= func_d;
      wind_q      <= wind_d;
    end
  end

  // ----------------------------------------------------------------------
  // Skip bands
  // ----------------------------------------------------------------------
  logic [2:0]    band_hit;
  logic [RW-1:0] target_adj;

  // Empty band (upper not above lower) is inactive, so defaults do nothing
  for (genvar g = 0; g < 3; g++) begin : g_band
    assign band_hit[g] =
      (band_hi_q[g*RW +: RW] > band_lo_q[g*RW +: RW]) &&
      (speed_request_i > band_lo_q[g*RW +: RW]) &&
      (speed_request_i < band_hi_q[g*RW +: RW]);
  end

  // Lowest-numbered hit band (band 0 first) wins; settles on its lower edge
  always_comb begin
    target_adj = speed_request_i;
    for (int i = 2; i >= 0; i--) begin
      if (band_hit[i]) begin
        target_adj = band_lo_q[i*RW +: RW]; // R05
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------------
  tss_timer_if grace_t ();
  tss_timer_if phase_t ();

  tss_sec_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_grace (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (grace_t.tmr)
  );

  tss_sec_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_phase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (phase_t.tmr)
  );

  // ----------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------
  tss_pkg::tss_state_e state_q, state_d;
  logic          over_q, over_d, under_q, under_d;
  logic          entered_q, entered_d, low_stop_q, low_stop_d;
  logic          relay_q, relay_d, rstart_q, rstart_d;
  logic [RW-1:0] target_q, target_d;
  logic          phase_done;

  assign grace_t.run   = (state_q == tss_pkg::ST_RUN) && over_q; // R06
  assign grace_t.limit = grace_q;
  // Timer held idle on the entry cycle so each phase restarts from zero
  assign phase_t.run   = ((state_q == tss_pkg::ST_LOWSPD) ||
                          (state_q == tss_pkg::ST_RAMP)) && !entered_q;
  assign phase_t.limit = (state_q == tss_pkg::ST_RAMP) ? ramp_time_q
                                                       : low_time_q;
  assign phase_done    = phase_t.expired && !entered_q;

  always_comb begin
    state_d    = state_q;
    over_d     = over_q;
    under_d    = under_q;
    low_stop_d = low_stop_q;
    target_d   = '0;
    if (speed_valid_i) begin // R10
      over_d  = speed_i > over_thr_q; // R01
      under_d = speed_i <= under_thr_q; // R07
    end
    unique case (state_q)
      tss_pkg::ST_IDLE: begin
        if (run_request_i) begin
          state_d    = tss_pkg::ST_RUN;
          low_stop_d = 1'b0;
        end
      end
      tss_pkg::ST_RUN: begin
        target_d = target_adj; // R05
        // Expiry alone is stale once speed has dropped back under
        if (grace_t.expired && over_q) begin
          state_d = tss_pkg::ST_RAMP; // R01
        end else if (under_q) begin
          state_d = tss_pkg::ST_LOWSPD; // R08
        end
      end
      tss_pkg::ST_LOWSPD: begin
        if (power_produced_i) begin
          state_d = tss_pkg::ST_RUN; // R08
        end else if (phase_done) begin
          state_d    = tss_pkg::ST_RAMP; // R04
          low_stop_d = 1'b1;
        end
      end
      tss_pkg::ST_RAMP: begin
        if (phase_done) begin
          state_d = tss_pkg::ST_STOP; // R02
        end
      end
      tss_pkg::ST_STOP: begin
        if (!run_request_i) begin
          state_d = tss_pkg::ST_IDLE;
        end
      end
    endcase
    if (!wind_q) begin
      state_d = tss_pkg::ST_IDLE; // R09
    end
    entered_d = state_d != state_q;
    rstart_d  = (state_d == tss_pkg::ST_RAMP) &&
                (state_q != tss_pkg::ST_RAMP);
    relay_d   = 1'b0;
    if (func_d == tss_pkg::RELAY_FUNC_CTRL) begin
      relay_d = (state_d == tss_pkg::ST_RUN) ||
                (state_d == tss_pkg::ST_LOWSPD); // R03
    end else if (func_d == tss_pkg::RELAY_FUNC_LOWSD) begin
      relay_d = !low_stop_d;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin // R10
      state_q    <= tss_pkg::ST_IDLE;
      over_q     <= 1'b0;
      under_q    <= 1'b0;
      entered_q  <= 1'b0;
      low_stop_q <= 1'b0;
      relay_q    <= 1'b0;
      rstart_q   <= 1'b0;
      target_q   <= '0;
    end else begin
      state_q    <= state_d;
      over_q     <= over_d;
      under_q    <= under_d;
      entered_q  <= entered_d;
      low_stop_q <= low_stop_d;
      relay_q    <= relay_d;
      rstart_q   <= rstart_d;
      target_q   <= target_d;
    end
  end

  assign relay_closed_o         = relay_q;
  assign ramp_start_o           = rstart_q;
  assign ramp_active_o          = state_q == tss_pkg::ST_RAMP;
  assign ramp_time_o            = ramp_time_q;
  assign min_speed_motoring_o   = state_q == tss_pkg::ST_LOWSPD;
  assign in_control_o           = state_q == tss_pkg::ST_RUN;
  assign pressure_ctrl_enable_o = !wind_q; // R09
  assign speed_target_o         = target_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  over_ramp_a: assert property ( // R01
    state_q == tss_pkg::ST_RUN && grace_t.expired && over_q && wind_q
    |=> ramp_active_o && ramp_start_o)
    else $error("Overspeed did not start the stop ramp");
  ramp_len_a: assert property ( // R02
    ramp_active_o && !phase_done && wind_q |=> ramp_active_o)
    else $error("Ramp left before its time elapsed");
  relay_ctrl_a: assert property ( // R03
    func_q == tss_pkg::RELAY_FUNC_CTRL && !cfg_load_i
    |=> relay_closed_o == (in_control_o || min_speed_motoring_o))
    else $error("Relay does not follow control state");
  low_range_a: assert property ( // R04
    low_time_q >= tss_pkg::LOW_TIME_MIN && low_time_q <= tss_pkg::LOW_TIME_MAX)
    else $error("Low-speed time out of range");
  band_out_a: assert property ( // R05
    $past(in_control_o) && !$past(cfg_load_i) |-> (band_hit == '0 ||
    (speed_target_o != speed_request_i) || !$stable(speed_request_i)))
    else $error("Target left inside a prohibited band");
  grace_cause_a: assert property ( // R06
    state_q == tss_pkg::ST_RUN && !over_q ##1 ramp_start_o |-> 1'b0)
    else $error("Ramp started without overspeed");
  low_power_a: assert property ( // R08
    min_speed_motoring_o && power_produced_i && wind_q |=> in_control_o)
    else $error("Power during low speed did not resume run");
  switch_off_a: assert property ( // R09
    !wind_switch_i ##1 !wind_q |=> state_q == tss_pkg::ST_IDLE)
    else $error("Supervision active with switch off");

  over_path_c: cover property (in_control_o && over_q ##[1:20] ramp_start_o);
  low_back_c:  cover property (min_speed_motoring_o ##1 in_control_o);
  ramp_stop_c: cover property (ramp_active_o ##1 state_q == tss_pkg::ST_STOP);

endmodule

// *** src/tss_timer_if.sv ***
// Carrier between the supervisor and its seconds timers.
// Assumes both ends share the supervisor clock.
`timescale 1ns/10ps
interface tss_timer_if;
  logic                      run;
  logic [tss_pkg::SEC_W-1:0] limit;
  logic                      expired;

  modport ctrl (output run, output limit, input expired);
  modport tmr  (input run, input limit, output expired);
endinterface

// *** verification/tss_turbine_model.sv ***
// Turbine model: reports generator speed and power to the supervisor.
// Assumes the bench sets the wind-driven rpm and power as plain levels.
`timescale 1ns/10ps
module tss_turbine_model #(
  parameter int unsigned UPD = 4
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [tss_pkg::RPM_W-1:0] rpm_i,
  input  wire logic                      producing_i,
  output logic      [tss_pkg::RPM_W-1:0] speed_o,
  output logic                           speed_valid_o,
  output logic                           power_o
);
  int unsigned cnt;

  // ----------------------------------------------------------------------
  // Speed updates
  // ----------------------------------------------------------------------
  // Between updates the speed bus carries junk, so a sampler that ignores
  // the valid strobe sees the wrong speed.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt           <= 0;
      speed_valid_o <= 1'b0;
      speed_o       <= '0;
      power_o       <= 1'b0;
    end else begin
      cnt           <= (cnt == UPD - 1) ? 0 : cnt + 1;
      speed_valid_o <= (cnt == UPD - 1);
      speed_o       <= (cnt == UPD - 1) ? rpm_i : ~rpm_i;
      power_o       <= producing_i;
    end
  end
endmodule

// *** verification/turbine_speed_supervisor_test.sv ***
// Bench for the turbine speed supervisor with a turbine model in front.
// Assumes a short second (CYC clocks) so timed ramps stay brief.
`timescale 1ns/10ps
module turbine_speed_supervisor_test;
  localparam int CYC = 4;
  localparam int UPD = 4;
  logic clk, rst, wind, run_req, producing, cfg_load, pwr, spd_vld;
  logic [11:0] rpm, spd, req, over_thr, under_thr, target;
  logic [6:0] grace, low_t, ramp_t, ramp_time;
  logic [35:0] lower, upper;
  logic [2:0] func;
  logic relay, ramp_start, ramp_act, min_spd, in_ctl, pce;
  int err_total;
  int samples_checked;
  int n;

  tss_turbine_model #(.UPD(UPD)) u_turbine (
    .clk_i(clk), .rst_i(rst), .rpm_i(rpm), .producing_i(producing),
    .speed_o(spd), .speed_valid_o(spd_vld), .power_o(pwr));

  tss_supervisor #(.CYC_PER_SEC(CYC)) u_dut (
    .clk_i(clk), .rst_i(rst), .wind_switch_i(wind),
    .run_request_i(run_req), .speed_i(spd), .speed_valid_i(spd_vld),
    .power_produced_i(pwr), .speed_request_i(req), .cfg_load_i(cfg_load),
    .overspeed_threshold_i(over_thr), .underspeed_threshold_i(under_thr),
    .overspeed_grace_time_i(grace), .low_speed_motoring_time_i(low_t),
    .stop_ramp_time_i(ramp_t), .skip_band_lower_i(lower),
    .skip_band_upper_i(upper), .status_relay_function_i(func),
    .relay_closed_o(relay), .ramp_start_o(ramp_start),
    .ramp_active_o(ramp_act), .ramp_time_o(ramp_time),
    .min_speed_motoring_o(min_spd), .in_control_o(in_ctl),
    .pressure_ctrl_enable_o(pce), .speed_target_o(target));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task close_out;
    $display("Checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = ramp_start;
      1: pick = in_ctl;
      2: pick = min_spd;
      default: pick = !ramp_act;
    endcase
  endfunction

  // Counts cycles until the chosen flag is high; a spent bound ends the run
  task automatic wait_for(input int sel, input int lim, output int k);
    k = 0;
    while (pick(sel) !== 1'b1 && k < lim) begin
      tick(1);
      k++;
    end
    if (pick(sel) !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t waited=%h limit=%h", $time, k, lim);
      close_out();
    end
  endtask

  task automatic in_range(input int k, input int lo, input int hi);
    check({31'h0, (k >= lo && k <= hi)}, 32'h1);
  endtask

  task automatic load_cfg;
    cfg_load = 1'b1;
    tick(1);
    cfg_load = 1'b0;
    tick(1);
  endtask

  // Leaves the stopped state and waits to be back in control
  task automatic restart(input logic [11:0] safe_rpm);
    rpm = safe_rpm;
    run_req = 1'b0;
    tick(2 * UPD);
    run_req = 1'b1;
    wait_for(1, 8, n);
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    $display("MISMATCH t=%0t timeout=%h limit=%h", $time, 1, 0);
    close_out();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    wind = 1'b0;
    run_req = 1'b0;
    producing = 1'b0;
    cfg_load = 1'b0;
    rpm = 12'h0c8;
    req = 12'h000;
    over_thr = 12'h3e8;
    under_thr = 12'h1f4;
    grace = 7'h02;
    low_t = 7'h03;
    ramp_t = 7'h02;
    func = 3'h2;
    lower = {12'h000, 12'h000, 12'h064};
    upper = {12'h000, 12'h000, 12'h0c8};
    repeat (12) @(posedge clk);
    check(pce, 1'b1);
    check(ramp_time, 7'h0a);
    check(in_ctl, 1'b0);
    #1;
    rst = 1'b0;
    tick(2);
    wind = 1'b1;
    run_req = 1'b1;
    wait_for(1, 8, n);
    check(pce, 1'b0);
    check(relay, 1'b0);
    rpm = 12'h708;
    tick(3 * UPD);
    check(in_ctl, 1'b1);
    rpm = 12'h709;
    wait_for(0, UPD + 8, n);
    check(relay, 1'b0);
    wait_for(3, 60, n);
    in_range(n, 10 * CYC, 10 * CYC + 4);
    check(in_ctl, 1'b0);
    restart(12'h2bc);
    load_cfg();
    check(ramp_time, 7'h02);
    check(relay, 1'b1);
    for (int f = 0; f < 5; f++) begin
      func = f[2:0];
      load_cfg();
      check(relay, {1'b0, f == 2 || f == 3});
    end
    func = 3'h2;
    load_cfg();
    foreach (lower[i]) begin
      if (i < 4) begin
        req = (i == 0) ? 12'h096 : (i == 1) ? 12'h064 :
              (i == 2) ? 12'h0c8 : 12'h12c;
        tick(2);
        check(target, (i == 0) ? 12'h064 : req);
      end
    end
    rpm = 12'h3e8;
    tick(3 * UPD);
    check(in_ctl, 1'b1);
    rpm = 12'h3e9;
    wait_for(0, 2 * CYC + UPD + 8, n);
    in_range(n, 2 * CYC, 2 * CYC + UPD + 8);
    wait_for(3, 20, n);
    in_range(n, 2 * CYC, 2 * CYC + 4);
    restart(12'h2bc);
    rpm = 12'h190;
    wait_for(2, UPD + 6, n);
    check(relay, 1'b1);
    producing = 1'b1;
    rpm = 12'h2bc;
    wait_for(1, UPD + 6, n);
    // Power held until the new speed clears the underspeed flag
    tick(UPD + 2);
    check(in_ctl, 1'b1);
    producing = 1'b0;
    tick(UPD);
    rpm = 12'h1f4;
    wait_for(2, UPD + 6, n);
    wait_for(0, 5 * CYC + 8, n);
    in_range(n, 5 * CYC, 5 * CYC + 6);
    check(relay, 1'b0);
    wait_for(3, 20, n);
    restart(12'h2bc);
    wind = 1'b0;
    tick(3);
    check(in_ctl, 1'b0);
    check(pce, 1'b1);
    close_out();
  end
endmodule
